// [nsp_pkg.sv]
// Package for the nonvolatile section and page buffer controller.
// Assumes one processor clock domain and a synchronous active-high reset.
package nsp_pkg;
  // ==========================================================
  // Memory map
  localparam int ADDR_W = 16;
  localparam int FLASH_BYTES = 8192;
  localparam logic [15:0] FLASH_BASE = 16'h8000;
  localparam logic [15:0] EEPROM_BASE = 16'h1400;
  localparam logic [15:0] EEPROM_BYTES = 16'h0080;
  localparam logic [15:0] USERROW_BASE = 16'h1300;
  localparam logic [15:0] USERROW_BYTES = 16'h0020;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_AW = 6;
  localparam int GRANULE_SHIFT = 8;
  // ==========================================================
  // Unlock
  localparam logic [7:0] SELF_PROGRAM_KEY = 8'h9D;
  localparam logic [2:0] UNLOCK_INSNS = 3'h4;
  // ==========================================================
  // Commands
  typedef enum logic [2:0] {
    NSP_CMD_NONE = 3'h0, NSP_CMD_WRITE = 3'h1, NSP_CMD_ERASE = 3'h2, NSP_CMD_ERWR = 3'h3,
    NSP_CMD_CLEAR = 3'h4, NSP_CMD_CHIP = 3'h5, NSP_CMD_EEER = 3'h6, NSP_CMD_FUSE = 3'h7
  } nsp_cmd_t;
  // Memory kinds
  typedef enum logic [1:0] {NSP_MEM_FLASH = 2'h0, NSP_MEM_EEPROM = 2'h1, NSP_MEM_USER = 2'h2,
    NSP_MEM_NONE = 2'h3} nsp_mem_t;
  // Flash regions
  typedef enum logic [1:0] {NSP_RGN_BOOT = 2'h0, NSP_RGN_CODE = 2'h1, NSP_RGN_DATA = 2'h2} nsp_rgn_t;
  // Sequencer states, Gray along idle-erase-write-done
  typedef enum logic [1:0] {NSP_ST_IDLE = 2'h0, NSP_ST_ERASE = 2'h1, NSP_ST_WRITE = 2'h3,
    NSP_ST_DONE = 2'h2} nsp_st_t;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int ERASE_US = 4000;
  localparam int WRITE_US = 2000;
  localparam int ERASE_CYC = ERASE_US * (CLK_HZ / 1_000_000);
  localparam int WRITE_CYC = WRITE_US * (CLK_HZ / 1_000_000);
  localparam logic [2:0] ERR_NONE = 3'h0;
endpackage

// [nsp_if.sv]
// Interface between processor end and the controller.
// Assumes both ends share I_CLK.
`timescale 1ns/1ps
`default_nettype none
interface nsp_if;
  import nsp_pkg::*;
  // Memory port
  logic req;
  logic we;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  // Unlock and control
  logic key_we;
  logic [7:0] key;
  logic cmd_we;
  logic [2:0] cmd;
  logic ctl_we;
  logic [1:0] locks;
  logic insn_done;
  logic sleep_insn;
  logic wake;
  logic dbg_halt;
  logic dbg_port;
  logic [1:0] exec_rgn;
  // Status
  logic flash_busy;
  logic ee_busy;
  logic wr_error;
  logic cpu_stall;
  logic clk_req;
  logic [2:0] cmd_rb;
  modport dev (input req, we, addr, wdata, key_we, key, cmd_we, cmd, ctl_we, locks, insn_done,
    sleep_insn, wake, dbg_halt, dbg_port, exec_rgn,
    output rdata, ack, flash_busy, ee_busy, wr_error, cpu_stall, clk_req, cmd_rb);
  modport host (output req, we, addr, wdata, key_we, key, cmd_we, cmd, ctl_we, locks, insn_done,
    sleep_insn, wake, dbg_halt, dbg_port, exec_rgn,
    input rdata, ack, flash_busy, ee_busy, wr_error, cpu_stall, clk_req, cmd_rb);
endinterface
`default_nettype wire

// [nsp_dev.sv]
// Controller end: regions, locks, page buffer, unlock window and sequencer.
// Assumes the host end drives the interface on I_CLK; array is modelled by flops.
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module nsp_dev
  import nsp_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int WRITE_CYCLES = WRITE_CYC,
  parameter logic [7:0] BOOT_END = 8'h04,
  parameter logic [7:0] APP_END = 8'h08
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Processor side
  nsp_if.dev bus
);
  localparam int FL_AW = $clog2(FLASH_BYTES);
  localparam int CNT_W = 24;

  // ==========================================================
  // Address decode
  wire logic in_flash = bus.addr >= FLASH_BASE;
  wire logic in_ee = (bus.addr >= EEPROM_BASE) && (bus.addr < EEPROM_BASE + EEPROM_BYTES);
  wire logic in_user = (bus.addr >= USERROW_BASE) && (bus.addr < USERROW_BASE + USERROW_BYTES);
  wire nsp_mem_t acc_mem = in_flash ? NSP_MEM_FLASH : in_ee ? NSP_MEM_EEPROM :
    in_user ? NSP_MEM_USER : NSP_MEM_NONE;
  wire logic [15:0] off = in_flash ? bus.addr - FLASH_BASE : in_ee ? bus.addr - EEPROM_BASE :
    bus.addr - USERROW_BASE;
  wire logic [PAGE_AW-1:0] col = off[PAGE_AW-1:0];

  // Region of an offset; zero settings give boot over all, code end zero spans to end
  function automatic nsp_rgn_t rgn_of(input logic [15:0] o);
    logic [15:0] be;
    logic [15:0] ae;
    be = {BOOT_END, 8'h00};
    ae = {APP_END, 8'h00};
    if (BOOT_END == 8'h00 && APP_END == 8'h00) begin
      rgn_of = NSP_RGN_BOOT;
    end else if (o < be) begin
      rgn_of = NSP_RGN_BOOT;
    end else if (APP_END == 8'h00 || o < ae) begin
      rgn_of = NSP_RGN_CODE;
    end else begin
      rgn_of = NSP_RGN_DATA;
    end
  endfunction

  // ==========================================================
  // State
  logic [7:0] buf_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mark_r;
  // Arrays power up erased; reset leaves their contents alone
  logic [7:0] flash_r [FLASH_BYTES] = '{default: 8'hFF};
  logic [7:0] ee_r [EEPROM_BYTES] = '{default: 8'hFF};
  logic [7:0] user_r [USERROW_BYTES] = '{default: 8'hFF};
  logic [15:0] page_r;
  nsp_mem_t pmem_r;
  nsp_st_t st_r;
  nsp_cmd_t op_r;
  logic [CNT_W-1:0] cnt_r;
  logic [2:0] win_r;
  logic code_lock_r;
  logic boot_lock_r;
  logic err_r;
  logic [7:0] rdata_r;
  logic ack_r;

  wire logic busy = st_r != NSP_ST_IDLE;
  wire logic run = !bus.dbg_halt;
  wire nsp_rgn_t tgt_rgn = rgn_of(page_r);

  // Directional write permission for the selected page
  wire logic wr_ok = (pmem_r == NSP_MEM_FLASH) ?
    (tgt_rgn == NSP_RGN_CODE && bus.exec_rgn == NSP_RGN_BOOT && !code_lock_r) ||
    (tgt_rgn == NSP_RGN_DATA && bus.exec_rgn != NSP_RGN_DATA) :
    (pmem_r == NSP_MEM_USER && bus.dbg_port) || bus.exec_rgn != NSP_RGN_DATA;

  wire logic mem_acc = bus.req && acc_mem != NSP_MEM_NONE;
  wire logic rd_blocked = boot_lock_r && in_flash && rgn_of(off) == NSP_RGN_BOOT;
  wire logic take = bus.req && !ack_r && !(busy && mem_acc && !bus.we);
  wire logic store = take && bus.we && acc_mem != NSP_MEM_NONE && run;
  wire logic cmd_ok = bus.cmd_we && win_r != 3'h0 && !busy && run;
  wire nsp_cmd_t cmd_in = nsp_cmd_t'(bus.cmd);
  wire logic op_end = (st_r == NSP_ST_ERASE || st_r == NSP_ST_WRITE) && cnt_r == '0 && run;
  wire logic clr_buf = bus.wake || (cmd_ok && cmd_in == NSP_CMD_CLEAR) || st_r == NSP_ST_DONE;

  // ==========================================================
  // Unlock window
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      win_r <= 3'h0;
    end else if (bus.key_we && bus.key == SELF_PROGRAM_KEY) begin
      win_r <= UNLOCK_INSNS;
    end else if (mem_acc || bus.sleep_insn || bus.cmd_we) begin
      win_r <= 3'h0;
    end else if (bus.insn_done && win_r != 3'h0) begin
      win_r <= win_r - 3'h1;
    end
  end

  // Lock bits: set-only until reset
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      code_lock_r <= 1'b0;
      boot_lock_r <= 1'b0;
    end else if (bus.ctl_we) begin
      code_lock_r <= code_lock_r | bus.locks[0];
      boot_lock_r <= boot_lock_r | bus.locks[1];
    end
  end

  // ==========================================================
  // Page buffer, shared by every memory
  always_ff @(posedge I_CLK) begin
    if (I_SRST || clr_buf) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_r[i] <= 8'hFF;
      end
      mark_r <= '0;
    end else if (store && !busy) begin
      buf_r[col] <= buf_r[col] & bus.wdata;
      mark_r[col] <= 1'b1;
    end
  end

  // Page select follows the last store made while idle
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      page_r <= 16'h0000;
      pmem_r <= NSP_MEM_NONE;
    end else if (store && !busy) begin
      page_r <= {off[15:PAGE_AW], {PAGE_AW{1'b0}}};
      pmem_r <= acc_mem;
    end
  end

  // ==========================================================
  // Sequencer; array changes only through commands
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_r <= NSP_ST_IDLE;
      op_r <= NSP_CMD_NONE;
      cnt_r <= '0;
      err_r <= 1'b0;
    end else if (run) begin
      case (st_r)
        NSP_ST_IDLE: begin
          if (cmd_ok && cmd_in inside {NSP_CMD_WRITE, NSP_CMD_ERASE, NSP_CMD_ERWR}) begin
            op_r <= cmd_in;
            if (!wr_ok || pmem_r == NSP_MEM_NONE) begin
              err_r <= 1'b1;
            end else if (cmd_in == NSP_CMD_WRITE) begin
              st_r <= NSP_ST_WRITE;
              cnt_r <= CNT_W'(WRITE_CYCLES - 1);
            end else begin
              st_r <= NSP_ST_ERASE;
              cnt_r <= CNT_W'(ERASE_CYCLES - 1);
            end
          end
        end
        NSP_ST_ERASE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - CNT_W'(1);
          end else if (op_r == NSP_CMD_ERWR) begin
            st_r <= NSP_ST_WRITE;
            cnt_r <= CNT_W'(WRITE_CYCLES - 1);
          end else begin
            st_r <= NSP_ST_DONE;
          end
        end
        NSP_ST_WRITE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - CNT_W'(1);
          end else begin
            st_r <= NSP_ST_DONE;
          end
        end
        default: begin
          st_r <= NSP_ST_IDLE;
        end
      endcase
    end
  end

  // Array update at end of each phase: whole Flash page, marked EEPROM bytes
  always_ff @(posedge I_CLK) begin
    if (op_end) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pmem_r == NSP_MEM_FLASH) begin
          flash_r[FL_AW'(page_r) + FL_AW'(i)] <= (st_r == NSP_ST_ERASE) ? 8'hFF :
            flash_r[FL_AW'(page_r) + FL_AW'(i)] & buf_r[i];
        end else if (mark_r[i] && pmem_r == NSP_MEM_EEPROM && page_r + 16'(i) < EEPROM_BYTES) begin
          ee_r[7'(page_r) + 7'(i)] <= (st_r == NSP_ST_ERASE) ? 8'hFF : buf_r[i];
        end else if (mark_r[i] && pmem_r == NSP_MEM_USER && 16'(i) < USERROW_BYTES) begin
          user_r[i] <= (st_r == NSP_ST_ERASE) ? 8'hFF : buf_r[i];
        end
      end
    end
  end

  // ==========================================================
  // Load/store answer
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= take && run;
      if (take && !bus.we) begin
        rdata_r <= rd_blocked || acc_mem == NSP_MEM_NONE ? 8'hFF :
          in_flash ? flash_r[FL_AW'(off)] : in_ee ? ee_r[7'(off)] : user_r[5'(off)];
      end
    end
  end

  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;
  assign bus.flash_busy = busy && pmem_r == NSP_MEM_FLASH;
  assign bus.ee_busy = busy && pmem_r != NSP_MEM_FLASH;
  assign bus.cpu_stall = bus.flash_busy;
  assign bus.clk_req = busy;
  assign bus.wr_error = err_r;
  assign bus.cmd_rb = op_r;
endmodule
`default_nettype wire

// [nsp_host.sv]
// Processor end: takes Wishbone orders and drives loads, stores and commands.
// Assumes a classic Wishbone master on I_CLK; register map is local.
`timescale 1ns/1ps
`default_nettype none
module nsp_host
  import nsp_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Wishbone slave
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  // Context
  input wire logic [1:0] I_EXEC_RGN,
  input wire logic I_SLEEP,
  input wire logic I_WAKE,
  input wire logic I_DBG_HALT,
  // Controller side
  nsp_if.host link
);
  localparam logic [7:0] R_ADDR = 8'h00;
  localparam logic [7:0] R_DATA = 8'h04;
  localparam logic [7:0] R_CMD = 8'h08;
  localparam logic [7:0] R_STAT = 8'h0C;

  logic pend_r;
  logic [31:0] dat_r;
  logic [15:0] addr_r;
  logic ack_r;

  wire logic hit = I_WB_CYC && I_WB_STB && !ack_r;
  wire logic st_mem = hit && I_WB_ADR == R_DATA;
  wire logic is_wr = I_WB_WE && I_WB_SEL[0];
  wire logic done = st_mem ? (pend_r && link.ack) : hit;
  wire logic [31:0] stat = {24'h0, 1'b0, link.cmd_rb, link.cpu_stall, link.wr_error, link.ee_busy, link.flash_busy};

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      pend_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      addr_r <= 16'h0;
    end else begin
      ack_r <= done;
      pend_r <= st_mem && !(pend_r && link.ack);
      if (hit && I_WB_WE && I_WB_ADR == R_ADDR && I_WB_SEL[0]) begin
        addr_r <= I_WB_DAT[15:0];
      end
      if (st_mem && pend_r && link.ack) begin
        dat_r <= {24'h0, link.rdata};
      end else if (hit && I_WB_ADR == R_STAT) begin
        dat_r <= stat;
      end else if (hit) begin
        dat_r <= 32'h0;
      end
    end
  end

  // Memory access held until the controller answers
  assign link.req = pend_r && !link.ack;
  assign link.we = is_wr;
  assign link.addr = addr_r;
  assign link.wdata = I_WB_DAT[7:0];
  // Key then command within the next four instructions
  assign link.key_we = hit && is_wr && I_WB_ADR == R_CMD && I_WB_DAT[8];
  assign link.key = SELF_PROGRAM_KEY;
  assign link.cmd_we = hit && is_wr && I_WB_ADR == R_CMD && !I_WB_DAT[8];
  assign link.cmd = I_WB_DAT[2:0];
  assign link.ctl_we = hit && is_wr && I_WB_ADR == R_CMD && I_WB_DAT[9];
  assign link.locks = I_WB_DAT[11:10];
  assign link.insn_done = hit;
  assign link.sleep_insn = I_SLEEP;
  assign link.wake = I_WAKE;
  assign link.dbg_halt = I_DBG_HALT;
  assign link.dbg_port = 1'b0;
  assign link.exec_rgn = I_EXEC_RGN;
  assign O_WB_ACK = ack_r;
  assign O_WB_DAT = dat_r;
endmodule
`default_nettype wire

// [nsp_monitor.sv]
// Checker on the link between the processor end and the controller.
// Assumes one clock domain and I_SRST synchronous, active high.
`timescale 1ns/1ps
`default_nettype none
module nsp_monitor
  import nsp_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Link signals
  input wire logic req,
  input wire logic we,
  input wire logic ack,
  input wire logic key_we,
  input wire logic [7:0] key,
  input wire logic cmd_we,
  input wire logic sleep_insn,
  input wire logic dbg_halt,
  input wire logic flash_busy,
  input wire logic ee_busy,
  input wire logic cpu_stall,
  input wire logic clk_req,
  input wire logic [2:0] cmd_rb
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  // ==========================================================
  // Unlock window and command age
  logic open_r;
  logic [2:0] since_cmd_r;
  wire logic busy = flash_busy | ee_busy;
  always_ff @(posedge I_CLK) begin
    if (I_SRST | req | sleep_insn) begin
      open_r <= 1'b0;
    end else if (key_we) begin
      open_r <= (key == SELF_PROGRAM_KEY);
    end
  end
  always_ff @(posedge I_CLK) begin
    if (I_SRST | cmd_we) begin
      since_cmd_r <= 3'h0;
    end else if (since_cmd_r != 3'h7) begin
      since_cmd_r <= since_cmd_r + 3'h1;
    end
  end
  // ==========================================================
  // Properties
  sequence s_read_answer;
    ack && !we;
  endsequence
  sequence s_busy_start;
    $rose(busy);
  endsequence
  a_read_stall: assert property (s_read_answer |-> !$past(busy))
    else $error("read answered while array busy");
  a_halt_no_ack: assert property (ack |-> !$past(dbg_halt))
    else $error("access answered during debug halt");
  a_flash_stalls: assert property (flash_busy |-> cpu_stall)
    else $error("flash operation without processor stall");
  a_ee_runs: assert property (ee_busy && !flash_busy |-> !cpu_stall)
    else $error("processor stalled by eeprom operation");
  a_clock_kept: assert property (busy |-> clk_req)
    else $error("clock request dropped while busy");
  a_one_buffer: assert property (!(flash_busy && ee_busy))
    else $error("flash and eeprom busy together");
  a_cmd_guard: assert property ($changed(cmd_rb) |-> $past(open_r))
    else $error("command taken without open unlock window");
  a_busy_cause: assert property (s_busy_start |-> since_cmd_r < 3'h6)
    else $error("array operation started without command");
endmodule
`default_nettype wire

// [nvm_section_and_page_buffer_ctrl_test.sv]
// Testbench: host end and controller end joined by the link.
// Assumes offsets 0x00 address, 0x04 data, 0x08 control, 0x0C status.
`timescale 1ns/1ps
`default_nettype none
module nvm_section_and_page_buffer_ctrl_test;
  import nsp_pkg::*;
  localparam logic [1:0] PRG [5] = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h0};
  localparam logic [15:0] PAD [5] = '{16'h8000, 16'h8802, 16'h8802, 16'h8404, 16'h8404};
  localparam logic [7:0] PDT [5] = '{8'h00, 8'h00, 8'h5A, 8'h00, 8'h00};
  localparam logic [4:0] PERR = 5'b01011;
  localparam logic [31:0] KEYW = {23'h0, 1'b1, SELF_PROGRAM_KEY};
  logic clk, srst, cyc, we, slp, wake, ack, halt;
  logic [7:0] adr;
  logic [31:0] dw, dr, q;
  logic [1:0] rgn;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  nsp_if link_if ();
  nsp_host nsp_host_i (.I_CLK(clk), .I_SRST(srst), .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we),
    .I_WB_SEL(4'hF), .I_WB_ADR(adr), .I_WB_DAT(dw), .O_WB_DAT(dr), .O_WB_ACK(ack), .I_EXEC_RGN(rgn),
    .I_SLEEP(slp), .I_WAKE(wake), .I_DBG_HALT(halt), .link(link_if));
  nsp_dev #(.ERASE_CYCLES(10), .WRITE_CYCLES(10), .BOOT_END(8'h04), .APP_END(8'h08))
    nsp_dev_i (.I_CLK(clk), .I_SRST(srst), .bus(link_if));
  nsp_monitor nsp_monitor_i (.I_CLK(clk), .I_SRST(srst), .req(link_if.req), .we(link_if.we),
    .ack(link_if.ack), .key_we(link_if.key_we), .key(link_if.key), .cmd_we(link_if.cmd_we),
    .sleep_insn(link_if.sleep_insn), .dbg_halt(link_if.dbg_halt), .flash_busy(link_if.flash_busy),
    .ee_busy(link_if.ee_busy), .cpu_stall(link_if.cpu_stall), .clk_req(link_if.clk_req),
    .cmd_rb(link_if.cmd_rb));
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 500);
    q = dr;
    check("bus ack", {31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    @(posedge clk);
  endtask
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    wb(1'b1, 8'h00, {16'h0, a});
    wb(1'b1, 8'h04, {24'h0, d});
  endtask
  task automatic load(input logic [15:0] a, input logic [7:0] exp);
    wb(1'b1, 8'h00, {16'h0, a});
    wb(1'b0, 8'h04, 32'h0);
    check("memory byte", {24'h0, q[7:0]}, {24'h0, exp});
  endtask
  task automatic stat(input logic [31:0] m, input logic [31:0] exp);
    wb(1'b0, 8'h0C, 32'h0);
    check("status", q & m, exp);
  endtask
  task automatic cmd(input nsp_cmd_t c);
    wb(1'b1, 8'h08, KEYW);
    wb(1'b1, 8'h08, {29'h0, c});
  endtask
  task automatic idle();
    int n = 0;
    do begin
      wb(1'b0, 8'h0C, 32'h0);
      n++;
    end while (q[1:0] !== 2'b00 && n < 100);
    check("operation finished", {30'h0, q[1:0]}, 32'h0);
  endtask
  task automatic pulse(input logic w);
    slp <= !w;
    wake <= w;
    @(posedge clk);
    slp <= 1'b0;
    wake <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reset_dut();
    srst <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================================
  // Clock and run limit
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("CHECK FAILED run time expected 20000 seen %0d", cycles);
      test_done();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    srst = 1'b1;
    cyc = 1'b0;
    we = 1'b0;
    slp = 1'b0;
    wake = 1'b0;
    halt = 1'b0;
    adr = 8'h00;
    dw = 32'h0;
    rgn = 2'h0;
    reset_dut();
    stat(32'h7F, 32'h0);
    wb(1'b1, 8'h08, {29'h0, NSP_CMD_ERWR});
    stat(32'h7F, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, 8'h08, KEYW);
      if (k == 0) pulse(1'b0);
      if (k == 1) load(16'h8000, 8'hFF);
      if (k == 2) repeat (5) wb(1'b0, 8'h0C, 32'h0);
      wb(1'b1, 8'h08, {29'h0, NSP_CMD_ERWR});
      stat(32'h7F, 32'h0);
    end
    $display("Test unlock guard done");
    store(16'h8400, 8'hF0);
    store(16'h8400, 8'h3C);
    cmd(NSP_CMD_ERWR);
    repeat (2) @(posedge clk);
    check("flash busy", {31'h0, link_if.flash_busy}, 32'h1);
    pulse(1'b0);
    check("clock request", {31'h0, link_if.clk_req}, 32'h1);
    load(16'h8400, 8'h30);
    load(16'h8401, 8'hFF);
    stat(32'h77, 32'h30);
    store(16'h8800, 8'h00);
    cmd(NSP_CMD_ERASE);
    // Debug halt freezes the erase well past its normal length
    halt <= 1'b1;
    repeat (30) @(posedge clk);
    check("halted busy", {31'h0, link_if.flash_busy}, 32'h1);
    halt <= 1'b0;
    idle();
    store(16'h8801, 8'hA5);
    cmd(NSP_CMD_WRITE);
    idle();
    load(16'h8800, 8'hFF);
    load(16'h8801, 8'hA5);
    $display("Test flash page done");
    store(16'h1402, 8'h0F);
    store(16'h1405, 8'h55);
    cmd(NSP_CMD_ERWR);
    idle();
    store(16'h1403, 8'h00);
    cmd(NSP_CMD_CLEAR);
    idle();
    store(16'h1404, 8'h00);
    pulse(1'b1);
    store(16'h1402, 8'hF0);
    cmd(NSP_CMD_ERWR);
    idle();
    load(16'h1402, 8'hF0);
    load(16'h1403, 8'hFF);
    load(16'h1404, 8'hFF);
    load(16'h1405, 8'h55);
    store(16'h131F, 8'h12);
    cmd(NSP_CMD_ERWR);
    idle();
    load(16'h131F, 8'h12);
    $display("Test eeprom and user row done");
    for (int i = 0; i < 5; i++) begin
      reset_dut();
      rgn <= PRG[i];
      if (i == 3) wb(1'b1, 8'h08, 32'h0000_0600);
      store(PAD[i], PDT[i]);
      cmd(NSP_CMD_ERWR);
      idle();
      stat(32'h4, {29'h0, PERR[i], 2'h0});
      load(PAD[i], PERR[i] ? 8'hFF : PDT[i]);
    end
    $display("Test region protection done");
    test_done();
  end
endmodule
`default_nettype wire
